// ### pkg/eft_defines.svh
/*
  Register offsets, field positions, reset values and setting ranges of the
  earth-fault trip decision block.
  Assumes a byte-addressed AXI4-Lite slave with one aligned 32-bit word each.
*/
`ifndef EFT_DEFINES_SVH
`define EFT_DEFINES_SVH

`define EFT_OFF_CTRL        8'h00
`define EFT_OFF_COMP        8'h04
`define EFT_OFF_CHAR        8'h08
`define EFT_OFF_STATUS      8'h0C
`define EFT_OFF_IRQ_STAT    8'h10
`define EFT_OFF_IRQ_MASK    8'h14
`define EFT_OFF_DIFF        8'h18
`define EFT_OFF_BIAS        8'h1C

`define EFT_CTRL_OPER       0
`define EFT_CTRL_DIRCHK     1
`define EFT_COMP_PRI_LSB    0
`define EFT_COMP_NEU_LSB    16
`define EFT_CHAR_BASE_LSB   0
`define EFT_CHAR_SLOPE_LSB  8
`define EFT_CHAR_BRK_LSB    16
`define EFT_ST_TRIP         0
`define EFT_ST_DIR          1
`define EFT_ST_CHAR         2
`define EFT_ST_UBLK         3
`define EFT_ST_BOOST        4
`define EFT_EVT_TRIP        0
`define EFT_EVT_DIR         1

`define EFT_RST_OPER        1'h1
`define EFT_RST_DIRCHK      1'h1
`define EFT_RST_PRI         10'h064
`define EFT_RST_NEU         10'h1F4
`define EFT_RST_BASE        6'h1E
`define EFT_RST_SLOPE       7'h46
`define EFT_RST_BRK         8'h7D
`define EFT_RST_MASK        2'h0

`define EFT_PRI_MIN         16'h0014
`define EFT_PRI_MAX         16'h01F4
`define EFT_NEU_MIN         16'h0064
`define EFT_NEU_MAX         16'h03E8
`define EFT_BASE_MIN        16'h000A
`define EFT_BASE_MAX        16'h0032
`define EFT_SLOPE_MIN       16'h0032
`define EFT_SLOPE_MAX       16'h0064
`define EFT_BRK_MIN         16'h0064
`define EFT_BRK_MAX         16'h00C8

`define EFT_PCT_UNITY       32'h0000_0064
`define EFT_BOOST_FACTOR    32'h0000_0004

`define EFT_RESP_OKAY       2'h0
`define EFT_RESP_SLVERR     2'h2

`endif

// ### pkg/eft_pkg.sv
/*
  Types of the earth-fault trip decision block: value widths, bus states and
  the packed state record of the top module.
  Assumes eft_defines.svh supplies all numeric constants.
*/
package eft_pkg;

    typedef logic        [15:0] eft_raw_t;
    typedef logic signed [19:0] eft_cur_t;
    typedef logic        [21:0] eft_mag_t;
    typedef logic        [9:0]  eft_comp_t;
    typedef logic        [5:0]  eft_base_t;
    typedef logic        [6:0]  eft_slope_t;
    typedef logic        [7:0]  eft_brk_t;

    typedef enum logic {EFT_WR_COLLECT, EFT_WR_RESP} eft_wr_t;
    typedef enum logic {EFT_RD_IDLE, EFT_RD_RESP} eft_rd_t;

    typedef struct packed {
        eft_raw_t [7:0] samp;
        logic           userBlk;
        logic           sensBoost;
        logic           operOn;
        logic           dirChk;
        eft_comp_t      priComp;
        eft_comp_t      neuComp;
        eft_base_t      baseSens;
        eft_slope_t     slope;
        eft_brk_t       brk;
        logic           trip;
        logic           dirBlk;
        logic           charTrip;
        logic [1:0]     irqStat;
        logic [1:0]     irqMask;
        logic           irq;
        eft_mag_t       diffMeas;
        eft_mag_t       biasMeas;
        eft_wr_t        wrSt;
        logic           awHave;
        logic           wHave;
        logic [7:0]     awAddr;
        logic [31:0]    wData;
        logic [3:0]     wStrb;
        logic           awReady;
        logic           wReady;
        logic           bValid;
        logic [1:0]     bResp;
        eft_rd_t        rdSt;
        logic           arReady;
        logic           rValid;
        logic [31:0]    rData;
        logic [1:0]     rResp;
    } eft_state_t;

endpackage : eft_pkg

// ### pkg/eft_meas_if.sv
/*
  Carrier between the trip decision top and its two evaluation modules.
  Assumes compensated phasors in percent of the base current.
*/
`timescale 1ns/1ps
interface eft_meas_if;
    import eft_pkg::*;

    eft_cur_t   re [4];
    eft_cur_t   im [4];
    eft_base_t  baseSens;
    eft_slope_t slope;
    eft_brk_t   brk;
    logic       sensBoost;
    eft_mag_t   diff;
    eft_mag_t   bias;
    logic       charTrip;
    logic       dirBlock;

    modport src (output re, im, baseSens, slope, brk, sensBoost,
                 input  diff, bias, charTrip, dirBlock);
    modport chr (input  re, im, baseSens, slope, brk, sensBoost,
                 output diff, bias, charTrip);
    modport dir (input  re, im, output dirBlock);
endinterface : eft_meas_if

// ### src/eft_char.sv
/*
  Percentage differential characteristic with one breakpoint.
  Assumes index 3 of the carrier is the neutral current, 0 to 2 the phases.
*/
`timescale 1ns/1ps
`include "eft_defines.svh"
module eft_char
    import eft_pkg::*;
(
    eft_meas_if.chr m
);
    // Both sides are scaled by unity times boost so no division is needed.
    localparam logic [33:0] UNITY = 34'(`EFT_PCT_UNITY);
    localparam logic [33:0] BOOST = 34'(`EFT_BOOST_FACTOR);
    localparam logic [33:0] FULL  = 34'(`EFT_PCT_UNITY * `EFT_BOOST_FACTOR);

    // Max plus half min overestimates the magnitude by up to about 12 percent of true.
    function automatic eft_mag_t mag(input logic signed [21:0] a,
                                     input logic signed [21:0] b);
        eft_mag_t x;
        eft_mag_t y;
        x = eft_mag_t'((a < 0) ? -a : a);
        y = eft_mag_t'((b < 0) ? -b : b);
        return (x > y) ? x + (y >> 1) : y + (x >> 1);
    endfunction : mag

    logic signed [21:0] sumRe;
    logic signed [21:0] sumIm;
    eft_mag_t           mg [4];
    eft_mag_t           biasV;
    eft_mag_t           diffV;
    logic [33:0]        lhs;
    logic [33:0]        rhs;

    always_comb begin
        sumRe = '0;
        sumIm = '0;
        biasV = '0;
        for (int i = 0; i < 4; i++) begin
            sumRe = sumRe + 22'(m.re[i]);
            sumIm = sumIm + 22'(m.im[i]);
            mg[i] = mag(22'(m.re[i]), 22'(m.im[i]));
            if (mg[i] > biasV) begin
                biasV = mg[i];
            end
        end
        diffV = mag(sumRe, sumIm);
        lhs   = 34'(diffV) * FULL;
        rhs   = 34'(m.baseSens) * (m.sensBoost ? UNITY : FULL);
        if (biasV > eft_mag_t'(m.brk)) begin
            rhs = rhs + 34'(m.slope) * 34'(biasV - eft_mag_t'(m.brk)) * BOOST;
        end
        m.diff     = diffV;
        m.bias     = biasV;
        m.charTrip = lhs > rhs;
    end
endmodule : eft_char

// ### src/eft_dir.sv
/*
  Zero-sequence directional element.
  Assumes index 3 of the carrier is the neutral current, 0 to 2 the phases.
*/
`timescale 1ns/1ps
module eft_dir
    import eft_pkg::*;
(
    eft_meas_if.dir m
);
    logic signed [21:0] zsRe;
    logic signed [21:0] zsIm;
    logic signed [43:0] dot;

    // A negative dot product means the angle lies beyond a quarter turn.
    always_comb begin
        zsRe       = 22'(m.re[0]) + 22'(m.re[1]) + 22'(m.re[2]);
        zsIm       = 22'(m.im[0]) + 22'(m.im[1]) + 22'(m.im[2]);
        dot        = 44'(zsRe) * 44'(m.re[3]) + 44'(zsIm) * 44'(m.im[3]);
        m.dirBlock = dot[43];
    end
endmodule : eft_dir

// ### src/eft_trip_top.sv
/*
  Restricted earth-fault trip decision: samples phasors, compensates them,
  evaluates characteristic and direction, combines blocking, and exposes
  settings, status, measured values and interrupts over AXI4-Lite.
  Assumes phasor inputs synchronous to clk, in percent of CT rated current,
  and a master that keeps one write and one read outstanding at most.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "eft_defines.svh"

module eft_trip_top
    import eft_pkg::*;
(
    input  logic        clk,
    input  logic        arst_n,
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    input  eft_raw_t    il1Re,
    input  eft_raw_t    il1Im,
    input  eft_raw_t    il2Re,
    input  eft_raw_t    il2Im,
    input  eft_raw_t    il3Re,
    input  eft_raw_t    il3Im,
    input  eft_raw_t    inRe,
    input  eft_raw_t    inIm,
    input  logic        userBlockIn,
    input  logic        sensBoostIn,
    output logic        generalTripOut,
    output logic        dirBlockOut,
    output logic        irq
);
    function automatic eft_state_t resetState();
        eft_state_t r;
        r          = '0;
        r.operOn   = `EFT_RST_OPER;
        r.dirChk   = `EFT_RST_DIRCHK;
        r.priComp  = `EFT_RST_PRI;
        r.neuComp  = `EFT_RST_NEU;
        r.baseSens = `EFT_RST_BASE;
        r.slope    = `EFT_RST_SLOPE;
        r.brk      = `EFT_RST_BRK;
        r.irqMask  = `EFT_RST_MASK;
        r.wrSt     = EFT_WR_COLLECT;
        r.rdSt     = EFT_RD_IDLE;
        r.awReady  = 1'h1;
        r.wReady   = 1'h1;
        r.arReady  = 1'h1;
        return r;
    endfunction : resetState

    localparam eft_state_t       ST_RST = resetState();
    localparam logic signed [23:0] UNITY = 24'(`EFT_PCT_UNITY);

    // Bit 32 of the answer flags a mapped address.
    function automatic logic [32:0] regRead(input eft_state_t s, input logic [7:0] a);
        logic [31:0] d;
        logic        hit;
        d   = '0;
        hit = 1'h1;
        if (a == `EFT_OFF_CTRL) begin
            d[`EFT_CTRL_OPER]   = s.operOn;
            d[`EFT_CTRL_DIRCHK] = s.dirChk;
        end else if (a == `EFT_OFF_COMP) begin
            d[`EFT_COMP_PRI_LSB +: $bits(eft_comp_t)] = s.priComp;
            d[`EFT_COMP_NEU_LSB +: $bits(eft_comp_t)] = s.neuComp;
        end else if (a == `EFT_OFF_CHAR) begin
            d[`EFT_CHAR_BASE_LSB +: $bits(eft_base_t)]   = s.baseSens;
            d[`EFT_CHAR_SLOPE_LSB +: $bits(eft_slope_t)] = s.slope;
            d[`EFT_CHAR_BRK_LSB +: $bits(eft_brk_t)]     = s.brk;
        end else if (a == `EFT_OFF_STATUS) begin
            d[`EFT_ST_TRIP]  = s.trip;
            d[`EFT_ST_DIR]   = s.dirBlk;
            d[`EFT_ST_CHAR]  = s.charTrip;
            d[`EFT_ST_UBLK]  = s.userBlk;
            d[`EFT_ST_BOOST] = s.sensBoost;
        end else if (a == `EFT_OFF_IRQ_STAT) begin
            d[1:0] = s.irqStat;
        end else if (a == `EFT_OFF_IRQ_MASK) begin
            d[1:0] = s.irqMask;
        end else if (a == `EFT_OFF_DIFF) begin
            d[$bits(eft_mag_t)-1:0] = s.diffMeas;
        end else if (a == `EFT_OFF_BIAS) begin
            d[$bits(eft_mag_t)-1:0] = s.biasMeas;
        end else begin
            hit = 1'h0;
        end
        return {hit, d};
    endfunction : regRead

    function automatic logic [31:0] mergeBytes(input logic [31:0] o,
                                               input logic [31:0] n,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction : mergeBytes

    // Out-of-range settings are pulled to the nearest legal value.
    function automatic logic [15:0] clampSet(input logic [15:0] v,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clampSet

    eft_state_t  st;
    eft_state_t  next_st;
    logic [7:0]  wrAddr;
    logic [7:0]  rdAddr;
    logic [32:0] wrOld;
    logic [32:0] rdAns;
    logic [31:0] wrWord;
    logic [15:0] priC;
    logic [15:0] neuC;
    logic [15:0] baseC;
    logic [15:0] slopeC;
    logic [15:0] brkC;
    logic [1:0]  clr;
    logic [1:0]  evt;
    logic        blocked;
    logic        tripNow;

    eft_meas_if mi ();

    // Compensation divides, so each input is expressed in percent of base.
    for (genvar i = 0; i < 4; i++) begin : g_comp
        localparam bit IS_NEUTRAL = (i == 3);
        logic signed [23:0] cmp;
        assign cmp = $signed({14'h0000, IS_NEUTRAL ? st.neuComp : st.priComp});
        assign mi.re[i] = 20'((24'($signed(st.samp[2*i])) * UNITY) / cmp);
        assign mi.im[i] = 20'((24'($signed(st.samp[2*i+1])) * UNITY) / cmp);
    end

    assign mi.baseSens = st.baseSens;
    assign mi.slope    = st.slope;
    assign mi.brk      = st.brk;
    assign mi.sensBoost = st.sensBoost;

    eft_char u_char (
        .m (mi.chr)
    );

    eft_dir u_dir (
        .m (mi.dir)
    );

    assign wrAddr = {st.awAddr[7:2], 2'h0};
    assign rdAddr = {s_axi_araddr[7:2], 2'h0};
    assign wrOld  = regRead(st, wrAddr);
    assign rdAns  = regRead(st, rdAddr);
    assign wrWord = mergeBytes(wrOld[31:0], st.wData, st.wStrb);
    assign priC   = clampSet(16'(wrWord[`EFT_COMP_PRI_LSB +: $bits(eft_comp_t)]),
                             `EFT_PRI_MIN, `EFT_PRI_MAX);
    assign neuC   = clampSet(16'(wrWord[`EFT_COMP_NEU_LSB +: $bits(eft_comp_t)]),
                             `EFT_NEU_MIN, `EFT_NEU_MAX);
    assign baseC  = clampSet(16'(wrWord[`EFT_CHAR_BASE_LSB +: $bits(eft_base_t)]),
                             `EFT_BASE_MIN, `EFT_BASE_MAX);
    assign slopeC = clampSet(16'(wrWord[`EFT_CHAR_SLOPE_LSB +: $bits(eft_slope_t)]),
                             `EFT_SLOPE_MIN, `EFT_SLOPE_MAX);
    assign brkC   = clampSet(16'(wrWord[`EFT_CHAR_BRK_LSB +: $bits(eft_brk_t)]),
                             `EFT_BRK_MIN, `EFT_BRK_MAX);

    always_comb begin
        next_st = st;
        clr     = 2'h0;
        evt     = 2'h0;

        // All inputs are caught on the same edge so the decision is coherent.
        next_st.samp      = {inIm, inRe, il3Im, il3Re, il2Im, il2Re, il1Im, il1Re};
        next_st.userBlk   = userBlockIn;
        next_st.sensBoost = sensBoostIn;

        // The trip follows the conditions directly, with no delay stage.
        blocked = st.userBlk | (st.dirChk & mi.dirBlock);
        tripNow = mi.charTrip & ~blocked & st.operOn;
        next_st.trip     = tripNow;
        next_st.dirBlk   = mi.dirBlock;
        next_st.charTrip = mi.charTrip;
        next_st.diffMeas = mi.diff;
        next_st.biasMeas = mi.bias;

        if (st.awReady && s_axi_awvalid) begin
            next_st.awHave = 1'h1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (st.wReady && s_axi_wvalid) begin
            next_st.wHave = 1'h1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end

        case (st.wrSt)
            EFT_WR_COLLECT: begin
                if (st.awHave && st.wHave) begin
                    next_st.awHave = 1'h0;
                    next_st.wHave  = 1'h0;
                    next_st.bValid = 1'h1;
                    next_st.bResp  = `EFT_RESP_OKAY;
                    next_st.wrSt   = EFT_WR_RESP;
                    if (wrAddr == `EFT_OFF_CTRL) begin
                        next_st.operOn = wrWord[`EFT_CTRL_OPER];
                        next_st.dirChk = wrWord[`EFT_CTRL_DIRCHK];
                    end else if (wrAddr == `EFT_OFF_COMP) begin
                        next_st.priComp = priC[$bits(eft_comp_t)-1:0];
                        next_st.neuComp = neuC[$bits(eft_comp_t)-1:0];
                    end else if (wrAddr == `EFT_OFF_CHAR) begin
                        next_st.baseSens = baseC[$bits(eft_base_t)-1:0];
                        next_st.slope    = slopeC[$bits(eft_slope_t)-1:0];
                        next_st.brk      = brkC[$bits(eft_brk_t)-1:0];
                    end else if (wrAddr == `EFT_OFF_IRQ_STAT) begin
                        // Masked by the strobe so an unwritten lane clears nothing.
                        clr = st.wStrb[0] ? st.wData[1:0] : 2'h0;
                    end else if (wrAddr == `EFT_OFF_IRQ_MASK) begin
                        next_st.irqMask = wrWord[1:0];
                    end else if (!wrOld[32]) begin
                        next_st.bResp = `EFT_RESP_SLVERR;
                    end
                end
            end
            EFT_WR_RESP: begin
                if (s_axi_bready) begin
                    next_st.bValid = 1'h0;
                    next_st.wrSt   = EFT_WR_COLLECT;
                end
            end
            default: begin
                next_st.wrSt = EFT_WR_COLLECT;
            end
        endcase

        case (st.rdSt)
            EFT_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_st.rValid = 1'h1;
                    next_st.rData  = rdAns[31:0];
                    next_st.rResp  = rdAns[32] ? `EFT_RESP_OKAY : `EFT_RESP_SLVERR;
                    next_st.rdSt   = EFT_RD_RESP;
                end
            end
            EFT_RD_RESP: begin
                if (s_axi_rready) begin
                    next_st.rValid = 1'h0;
                    next_st.rdSt   = EFT_RD_IDLE;
                end
            end
            default: begin
                next_st.rdSt = EFT_RD_IDLE;
            end
        endcase

        // A new event outranks a clear landing in the same cycle.
        evt[`EFT_EVT_TRIP] = tripNow & ~st.trip;
        evt[`EFT_EVT_DIR]  = mi.dirBlock & ~st.dirBlk;
        next_st.irqStat    = (st.irqStat & ~clr) | evt;
        next_st.irq        = |(next_st.irqStat & next_st.irqMask);

        next_st.awReady = ~next_st.awHave;
        next_st.wReady  = ~next_st.wHave;
        next_st.arReady = (next_st.rdSt == EFT_RD_IDLE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready  = st.awReady;
    assign s_axi_wready   = st.wReady;
    assign s_axi_bvalid   = st.bValid;
    assign s_axi_bresp    = st.bResp;
    assign s_axi_arready  = st.arReady;
    assign s_axi_rvalid   = st.rValid;
    assign s_axi_rdata    = st.rData;
    assign s_axi_rresp    = st.rResp;
    assign generalTripOut = st.trip;
    assign dirBlockOut    = st.dirBlk;
    assign irq            = st.irq;
endmodule : eft_trip_top

// ### bench/eft_front_model.sv
/*
  Behavioural measurement front-end: drives the eight phasor components.
  Assumes sel changes just after a rising clock edge.
*/
`timescale 1ns/1ps
module eft_front_model
    import eft_pkg::*;
(
    input  logic [1:0] sel,
    output eft_raw_t   il1Re,
    output eft_raw_t   il1Im,
    output eft_raw_t   il2Re,
    output eft_raw_t   il2Im,
    output eft_raw_t   il3Re,
    output eft_raw_t   il3Im,
    output eft_raw_t   inRe,
    output eft_raw_t   inIm
);
    always_comb begin
        {il1Re, il1Im, il2Re, il2Im, il3Re, il3Im, inRe, inIm} = {8{16'h0001}};
        case (sel)
            2'h1: il1Re = 16'h0064;
            2'h2: il1Re = 16'h0014;
            2'h3: begin
                il1Re = 16'h012C;
                inRe  = 16'hFE0C;
            end
            default: ;
        endcase
    end
endmodule : eft_front_model

// ### bench/eft_trip_assertions.sv
/*
  Checker of the trip block's bus handshakes and trip output.
  Assumes binding to eft_trip_top, one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "eft_defines.svh"
module eft_trip_assertions (
    input logic        clk,
    input logic        arst_n,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        userBlockIn,
    input logic        generalTripOut,
    input logic        dirBlockOut,
    input logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    ublk_forces_low_a: assert property (
        $past(userBlockIn, 2) |-> !generalTripOut) else $error("trip under user block");
    rd_latency_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read answer dropped");
    ar_busy_a: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("address ready during answer");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    wr_latency_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response timing");
    aw_drop_a: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address ready held");
    unmapped_rd_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20 |=>
        s_axi_rresp == `EFT_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");

    cover property ($rose(generalTripOut));
    cover property ($rose(dirBlockOut));
    cover property ($rose(irq));
endmodule : eft_trip_assertions

bind eft_trip_top eft_trip_assertions i_eft_trip_assertions (
    .clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .userBlockIn, .generalTripOut, .dirBlockOut, .irq);

// ### bench/test_eft_trip_top.sv
/*
  Self-checking bench of the trip block: AXI4-Lite tasks and trip scenarios.
  Assumes the front-end model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "eft_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_eft_trip_top;
    import eft_pkg::*;
    logic        clk, arst_n, userBlockIn, sensBoostIn, generalTripOut, dirBlockOut, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sel;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    eft_raw_t    il1Re, il1Im, il2Re, il2Im, il3Re, il3Im, inRe, inIm;
    int          errors, n_compared;

    eft_front_model i_eft_front_model (.sel, .il1Re, .il1Im, .il2Re, .il2Im, .il3Re,
        .il3Im, .inRe, .inIm);
    eft_trip_top i_eft_trip_top (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .il1Re, .il1Im, .il2Re, .il2Im, .il3Re, .il3Im, .inRe, .inIm, .userBlockIn,
        .sensBoostIn, .generalTripOut, .dirBlockOut, .irq);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic bounded(input int n);
        if (n >= 100) begin
            errors++;
            conclude();
        end
    endtask : bounded

    // Sample edge, launch edge, then one edge to look.
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic aw, w;
        @(posedge clk);
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((aw || w) && n < 100) begin
            @(posedge clk);
            n++;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid && n < 100) begin
            @(posedge clk);
            n++;
        end
        s_axi_bready <= 1'b0;
        bounded(n);
        `CHK("bresp", er, s_axi_bresp)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(posedge clk); n++; end while (!s_axi_arready && n < 100);
        s_axi_arvalid <= 1'b0;
        do begin @(posedge clk); n++; end while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        bounded(n);
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask : rd

    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        {userBlockIn, sensBoostIn, sel, errors, n_compared} = '0;
        arst_n = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        settle();
        `CHK("trip", 1'b0, generalTripOut)
        rd(`EFT_OFF_CTRL, 32'h0000_0003, `EFT_RESP_OKAY);
        rd(`EFT_OFF_COMP, 32'h01F4_0064, `EFT_RESP_OKAY);
        rd(`EFT_OFF_CHAR, 32'h007D_461E, `EFT_RESP_OKAY);
        rd(8'h20, 32'h0000_0000, `EFT_RESP_SLVERR);
        wr(8'h24, 32'h0000_0001, `EFT_RESP_SLVERR);
        $display("map test done");
        wr(`EFT_OFF_CHAR, 32'h00FF_7F00, `EFT_RESP_OKAY);
        rd(`EFT_OFF_CHAR, 32'h00C8_640A, `EFT_RESP_OKAY);
        wr(`EFT_OFF_CHAR, 32'h0064_3232, `EFT_RESP_OKAY);
        rd(`EFT_OFF_CHAR, 32'h0064_3232, `EFT_RESP_OKAY);
        wr(`EFT_OFF_CHAR, 32'h007D_461E, `EFT_RESP_OKAY);
        wr(`EFT_OFF_COMP, 32'h07FF_0000, `EFT_RESP_OKAY);
        rd(`EFT_OFF_COMP, 32'h03E8_0014, `EFT_RESP_OKAY);
        wr(`EFT_OFF_COMP, 32'h01F4_0064, `EFT_RESP_OKAY);
        $display("range test done");
        sel <= 2'h1;
        settle();
        `CHK("trip", 1'b1, generalTripOut)
        rd(`EFT_OFF_STATUS, 32'h0000_0005, `EFT_RESP_OKAY);
        userBlockIn <= 1'b1;
        settle();
        `CHK("trip", 1'b0, generalTripOut)
        userBlockIn <= 1'b0;
        wr(`EFT_OFF_CTRL, 32'h0000_0002, `EFT_RESP_OKAY);
        settle();
        `CHK("trip", 1'b0, generalTripOut)
        wr(`EFT_OFF_CTRL, 32'h0000_0003, `EFT_RESP_OKAY);
        $display("block test done");
        sel <= 2'h2;
        settle();
        `CHK("trip", 1'b0, generalTripOut)
        sensBoostIn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("trip", 1'b0, generalTripOut)
        @(posedge clk);
        `CHK("trip", 1'b1, generalTripOut)
        sensBoostIn <= 1'b0;
        $display("boost test done");
        sel <= 2'h3;
        settle();
        `CHK("dirBlock", 1'b1, dirBlockOut)
        `CHK("trip", 1'b0, generalTripOut)
        rd(`EFT_OFF_DIFF, 32'h0000_00CB, `EFT_RESP_OKAY);
        rd(`EFT_OFF_BIAS, 32'h0000_012C, `EFT_RESP_OKAY);
        wr(`EFT_OFF_CTRL, 32'h0000_0001, `EFT_RESP_OKAY);
        settle();
        `CHK("trip", 1'b1, generalTripOut)
        wr(`EFT_OFF_CTRL, 32'h0000_0003, `EFT_RESP_OKAY);
        $display("direction test done");
        sel <= 2'h0;
        settle();
        rd(`EFT_OFF_IRQ_STAT, 32'h0000_0003, `EFT_RESP_OKAY);
        `CHK("irq", 1'b0, irq)
        wr(`EFT_OFF_IRQ_MASK, 32'h0000_0003, `EFT_RESP_OKAY);
        settle();
        `CHK("irq", 1'b1, irq)
        wr(`EFT_OFF_IRQ_STAT, 32'h0000_0001, `EFT_RESP_OKAY);
        rd(`EFT_OFF_IRQ_STAT, 32'h0000_0002, `EFT_RESP_OKAY);
        wr(`EFT_OFF_IRQ_MASK, 32'h0000_0001, `EFT_RESP_OKAY);
        settle();
        `CHK("irq", 1'b0, irq)
        wr(`EFT_OFF_IRQ_STAT, 32'h0000_0002, `EFT_RESP_OKAY);
        rd(`EFT_OFF_IRQ_STAT, 32'h0000_0000, `EFT_RESP_OKAY);
        $display("irq test done");
        conclude();
    end
endmodule : test_eft_trip_top
